// ===== hdl/test_point_pkg.sv
// Summary of operation
// - All eight test point pins are inputs while reset is held; after release they become outputs only under code 0b010.
// - The pin levels are captured at reset release as the starting test mode and kept in strap_value until the next reset.
// - The straps are sampled only on the low-to-high edge of reset; later pin changes are ignored.
// - Each pin has a weak pull-down, so an unstrapped pin reads zero and only a pull-up changes it.
// - A captured low code of all zeros is the default setting, the no-switching scenario.
// - Code 0b000 keeps all eight test point outputs in high impedance.
// - Code 0b010 drives the clock debug set: fast, half, variable clocks, fixed levels, slow clock.
// - The strap selection is only a default; software may change the selection after reset.
package test_point_pkg;

    localparam int PIN_COUNT = 8;
    localparam int CODE_WIDTH = 3;
    localparam int SYNC_STAGES = 2;

    // Mode codes on the three low strap pins
    localparam logic [2:0] MODE_QUIET = 3'h0;
    localparam logic [2:0] MODE_CLOCK_DEBUG = 3'h2;

    // Values after reset
    localparam logic [7:0] STRAP_RESET = 8'h00;
    localparam logic [2:0] CODE_RESET = 3'h0;
    localparam logic [7:0] PIN_OUT_RESET = 8'h00;
    localparam logic [7:0] PIN_OE_RESET = 8'h00;

    // Clock debug scenario: pin positions of the clock sources
    localparam int POS_FAST_CLK = 0;
    localparam int POS_HALF_CLK = 1;
    localparam int POS_VAR_CLK = 2;
    localparam int POS_SLOW_CLK = 7;

    // Clock debug scenario: fixed levels, bits 3 to 6 used
    localparam logic [7:0] CLOCK_DEBUG_LEVELS = 8'h68;
    localparam logic [7:0] CLOCK_DEBUG_OE = 8'hFF;

    // Nominal rates of the debug clock sources, in Hz
    localparam int FAST_CLK_HZ = 60000000;
    localparam int HALF_CLK_HZ = 30000000;
    localparam int SLOW_CLK_HZ = 7500000;

    typedef enum logic [1:0] {
        ST_HOLD,
        ST_CAPTURED,
        ST_RUN
    } port_state_t;

endpackage

// ===== hdl/strap_sync.sv
`timescale 1ns/100ps
// Plain synchroniser without reset so it keeps tracking the pins while reset is held
module strap_sync #(
    parameter int WIDTH = 8,
    parameter int STAGES = 2
) (
    input wire logic clk,               // System clock
    input wire logic [WIDTH-1:0] d,     // Asynchronous levels
    output logic [WIDTH-1:0] q          // Synchronised levels
);

    logic [WIDTH-1:0] stage_q [STAGES];

    // Only the last stage is read outside; first stage feeds the next one alone
    always_ff @(posedge clk) begin
        stage_q[0] <= d;
        for (int i = 1; i < STAGES; i++) begin
            stage_q[i] <= stage_q[i-1];
        end
    end

    assign q = stage_q[STAGES-1];

endmodule

// ===== hdl/test_point_port.sv
`timescale 1ns/100ps
module test_point_port #(
    parameter int PINS = test_point_pkg::PIN_COUNT
) (
    input wire logic clk,                     // 20 MHz system clock
    input wire logic nrst,                    // Active-low system reset, asynchronous
    input wire logic [PINS-1:0] test_point_port_in,   // Pin levels seen at the pads
    output logic [PINS-1:0] test_point_port_out,      // Pin output values
    output logic [PINS-1:0] test_point_port_oe,       // High while a pin is driven
    input wire logic dbg_fast_clk,            // Fast debug clock source, same domain
    input wire logic dbg_half_clk,            // Half-rate debug clock source
    input wire logic dbg_var_clk,             // Variable debug clock source
    input wire logic dbg_slow_clk,            // Slow debug clock source
    input wire logic sw_sel_we,               // Pulse: load sw_sel_code as selection
    input wire logic [2:0] sw_sel_code,       // Software selection code
    input wire logic sw_sel_restore,          // Pulse: return to captured strap code
    output logic [PINS-1:0] strap_value,      // Captured strap levels
    output logic [2:0] active_code,           // Selection code in force
    output logic port_active                  // High from the second edge after release, whatever the code
);

    // Phases: while reset is held every pin is an input and the sync chain
    // keeps tracking the straps; the first edge after release captures them
    // and the second turns the port round. Software may then replace the code.
    // Limitation: debug clocks are re-timed by one flop, so the fastest pin
    // toggle is half the system clock rate and every pin lags its source.
    // Trade-off: one extra cycle before driving, so a strap is never fought.

    ////////////////////////////////////////////////////////////////////////////
    // Declarations

    // Pin levels after the two-flop chain
    logic [PINS-1:0] pin_sync;

    // Phase and captured straps
    test_point_pkg::port_state_t state_q;
    test_point_pkg::port_state_t state_d;
    logic [PINS-1:0] strap_q;

    // Selection code in force
    logic [2:0] code_q;
    logic [2:0] code_d;

    // Pin driver registers and the turn-round flag
    logic [PINS-1:0] out_q;
    logic [PINS-1:0] out_d;
    logic [PINS-1:0] oe_q;
    logic [PINS-1:0] oe_d;
    logic active_q;

    // Debug sources at their pin positions
    logic [PINS-1:0] clk_srcs;

    ////////////////////////////////////////////////////////////////////////////
    // Decoding of the selection code

    // Output enables for a code; unknown codes stay quiet
    function automatic logic [PINS-1:0] code_oe(input logic [2:0] code);
        logic [PINS-1:0] oe;
        oe = '0;
        case (code)
            test_point_pkg::MODE_QUIET: begin
                oe = '0;
            end
            test_point_pkg::MODE_CLOCK_DEBUG: begin
                oe = PINS'(test_point_pkg::CLOCK_DEBUG_OE);
            end
            default: begin
                oe = '0;
            end
        endcase
        return oe;
    endfunction

    // Output values for a code; quiet codes drive zero behind a low enable
    function automatic logic [PINS-1:0] code_out(input logic [2:0] code,
                                                 input logic [PINS-1:0] srcs);
        logic [PINS-1:0] val;
        val = '0;
        case (code)
            test_point_pkg::MODE_CLOCK_DEBUG: begin
                val = PINS'(test_point_pkg::CLOCK_DEBUG_LEVELS) | srcs;
            end
            default: begin
                val = '0;
            end
        endcase
        return val;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Pin input synchroniser

    // Not reset, so the chain still follows the straps while reset is held
    strap_sync #(
        .WIDTH(PINS),
        .STAGES(test_point_pkg::SYNC_STAGES)
    ) u_strap_sync (
        .clk(clk),
        .d(test_point_port_in),
        .q(pin_sync)
    );

    // Debug clock sources placed at their pin positions
    always_comb begin
        clk_srcs = '0;
        clk_srcs[test_point_pkg::POS_FAST_CLK] = dbg_fast_clk;
        clk_srcs[test_point_pkg::POS_HALF_CLK] = dbg_half_clk;
        clk_srcs[test_point_pkg::POS_VAR_CLK] = dbg_var_clk;
        clk_srcs[test_point_pkg::POS_SLOW_CLK] = dbg_slow_clk;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Phase control

    // Hold until reset lifts, capture once, then run until the next reset
    always_comb begin
        state_d = state_q;
        case (state_q)
            test_point_pkg::ST_HOLD: begin
                state_d = test_point_pkg::ST_CAPTURED;
            end
            test_point_pkg::ST_CAPTURED: begin
                state_d = test_point_pkg::ST_RUN;
            end
            test_point_pkg::ST_RUN: begin
                state_d = test_point_pkg::ST_RUN;
            end
            default: begin
                state_d = test_point_pkg::ST_HOLD;
            end
        endcase
    end

    // Phase register; reset drops it straight back to hold
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_q <= test_point_pkg::ST_HOLD;
        end else begin
            state_q <= state_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Strap capture

    // Caught on the first edge after release; the sync chain still holds
    // the levels seen during reset, before the pins turn round
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            strap_q <= PINS'(test_point_pkg::STRAP_RESET);
        end else if (state_q == test_point_pkg::ST_HOLD) begin
            strap_q <= pin_sync;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Selection code

    // Software load wins over restore; strap code is only the starting point
    always_comb begin
        code_d = code_q;
        if (state_q == test_point_pkg::ST_HOLD) begin
            code_d = pin_sync[2:0];
        end else if (sw_sel_we) begin
            code_d = sw_sel_code;
        end else if (sw_sel_restore) begin
            code_d = strap_q[2:0];
        end
    end

    // Code register; cleared by reset so no mode survives into the next capture
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            code_q <= test_point_pkg::CODE_RESET;
        end else begin
            code_q <= code_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin drivers

    // Nothing drives until the capture has settled, so straps are never fought
    always_comb begin
        if (state_q == test_point_pkg::ST_HOLD) begin
            oe_d = '0;
            out_d = '0;
        end else begin
            oe_d = code_oe(code_q);
            out_d = code_out(code_q, clk_srcs);
        end
    end

    // Reset clears the enables at once, so pins are inputs during reset
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            oe_q <= PINS'(test_point_pkg::PIN_OE_RESET);
            out_q <= PINS'(test_point_pkg::PIN_OUT_RESET);
        end else begin
            oe_q <= oe_d;
            out_q <= out_d;
        end
    end

    // Port turns round one edge after capture
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            active_q <= 1'b0;
        end else begin
            active_q <= (state_q != test_point_pkg::ST_HOLD);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    // Debug clocks pass a register, so they are limited to half the system rate
    assign test_point_port_out = out_q;
    assign test_point_port_oe = oe_q;
    assign strap_value = strap_q;
    assign active_code = code_q;
    assign port_active = active_q;

endmodule

// ===== test/test_point_checker.sv
`timescale 1ns/100ps
module test_point_checker #(
    parameter int PINS = 8
) (
    input wire logic clk, // Clock
    input wire logic nrst, // Reset
    input wire logic [PINS-1:0] test_point_port_in, // Pads
    input wire logic [PINS-1:0] test_point_port_out, // Pin values
    input wire logic [PINS-1:0] test_point_port_oe, // Pin enables
    input wire logic dbg_fast_clk, // Source
    input wire logic dbg_half_clk, // Source
    input wire logic dbg_var_clk, // Source
    input wire logic dbg_slow_clk, // Source
    input wire logic sw_sel_we, // Load pulse
    input wire logic [2:0] sw_sel_code, // Load code
    input wire logic sw_sel_restore, // Restore pulse
    input wire logic [PINS-1:0] strap_value, // Captured
    input wire logic [2:0] active_code, // In force
    input wire logic port_active // Outputs live
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    // First edge after release, then the one that turns the pins round
    sequence s_release;
        $rose(nrst);
    endsequence
    sequence s_dbg;
        port_active && active_code == 3'h2;
    endsequence
    chk_pins_idle_release: assert property (s_release |-> test_point_port_oe == 8'h00
        && !port_active) else $error("pins driven at release");
    chk_outputs_turn_on: assert property (s_release |=> (!port_active
        && test_point_port_oe == 8'h00) ##1 port_active)
        else $error("pins not turned to outputs");
    chk_strap_capture: assert property (s_release |=> strap_value ==
        $past(test_point_port_in, 3) && active_code == strap_value[2:0])
        else $error("strap capture wrong");
    chk_strap_hold: assert property (port_active |-> $stable(strap_value))
        else $error("strap value moved");
    chk_quiet_codes: assert property (port_active && active_code != 3'h2
        |=> test_point_port_oe == 8'h00) else $error("quiet code drives pins");
    chk_debug_levels: assert property (s_dbg |=> test_point_port_oe == 8'hFF
        && test_point_port_out[6:3] == 4'hD) else $error("debug levels wrong");
    chk_debug_clocks: assert property (s_dbg |=> {test_point_port_out[7],
        test_point_port_out[2:0]} == $past({dbg_slow_clk, dbg_var_clk, dbg_half_clk,
        dbg_fast_clk})) else $error("debug clocks wrong");
    chk_sw_load: assert property (port_active && sw_sel_we
        |=> active_code == $past(sw_sel_code)) else $error("software load lost");
    chk_sw_restore: assert property (port_active && sw_sel_restore && !sw_sel_we
        |=> active_code == strap_value[2:0]) else $error("restore lost");
endmodule
bind test_point_port test_point_checker #(.PINS(PINS)) chk (.clk(clk), .nrst(nrst),
    .test_point_port_in(test_point_port_in), .test_point_port_out(test_point_port_out),
    .test_point_port_oe(test_point_port_oe), .dbg_fast_clk(dbg_fast_clk),
    .dbg_half_clk(dbg_half_clk), .dbg_var_clk(dbg_var_clk), .dbg_slow_clk(dbg_slow_clk),
    .sw_sel_we(sw_sel_we), .sw_sel_code(sw_sel_code), .sw_sel_restore(sw_sel_restore),
    .strap_value(strap_value), .active_code(active_code), .port_active(port_active));

// ===== test/board_strap_model.sv
`timescale 1ns/100ps
// Board side: jumpered pull-ups on the low pins, upper pins left open
module board_strap_model (
    input wire logic [2:0] jumper, // Fitted pull-ups
    input wire logic [7:0] pin_out, // Device value
    input wire logic [7:0] pin_oe, // Device enable
    output logic [7:0] pad // Resolved levels
);
    logic [7:0] idle;
    // Open pins fall to the pull-down; upper pins never strapped high
    assign idle = {5'h00, jumper};
    // A driven pin shows the device value, a released one its pull level
    assign pad = (pin_oe & pin_out) | (~pin_oe & idle);
endmodule

// ===== test/test_point_port_tb_top.sv
`timescale 1ns/100ps
module test_point_port_tb_top;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic we = 1'b0;
    logic rs = 1'b0;
    logic [2:0] sc = 3'h0;
    logic [2:0] jmp = 3'h0;
    logic [3:0] dbg = 4'h0;
    logic [7:0] pad, pout, poe, sv;
    logic [2:0] ac;
    logic pa;
    logic [23:0] exp_q[$];
    logic [23:0] e;
    int num_errors = 0;
    int checks_done = 0;
    event look;
    ////////////////////////////////////////////////////////////////
    initial begin
        forever #25 clk = ~clk;
    end
    test_point_port dut (.clk(clk), .nrst(nrst), .test_point_port_in(pad),
        .test_point_port_out(pout), .test_point_port_oe(poe), .dbg_fast_clk(dbg[0]),
        .dbg_half_clk(dbg[1]), .dbg_var_clk(dbg[2]), .dbg_slow_clk(dbg[3]),
        .sw_sel_we(we), .sw_sel_code(sc), .sw_sel_restore(rs), .strap_value(sv),
        .active_code(ac), .port_active(pa));
    board_strap_model board (.jumper(jmp), .pin_out(pout), .pin_oe(poe), .pad(pad));
    ////////////////////////////////////////////////////////////////
    // Inputs move 5 ns after the edge; debug sources toggle at random
    task automatic step(input int n);
        repeat (n) begin
            @(posedge clk);
            #5;
            dbg = 4'($urandom);
        end
    endtask
    // Note the expected port state and hand it to the monitor
    task automatic expect_now(input logic [2:0] c, input logic [2:0] s, input logic on);
        logic hit;
        hit = on && (c == 3'h2);
        exp_q.push_back({on, 5'h00, s, c, hit ? 8'hFF : 8'h00, hit ? 4'hD : 4'h0});
        -> look;
    endtask
    task automatic wrap_up();
        if (num_errors == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // Monitor: oldest note against what the port shows now
    initial begin
        forever begin
            @(look);
            e = exp_q.pop_front();
            checks_done++;
            if ({pa, sv, ac, poe, pout[6:3]} !== e) begin
                num_errors++;
                $display("BAD port_state exp %h got %h", e, {pa, sv, ac, poe, pout[6:3]});
            end
        end
    end
    // Hang guard
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        wrap_up();
    end
    ////////////////////////////////////////////////////////////////
    // Each pass is a fresh reset, so later passes also cover mid-run reset
    initial begin
        logic [2:0] code;
        logic [2:0] c2;
        void'($urandom(32'hFF99A55C));
        for (int k = 0; k < 6; k++) begin
            code = (k == 0) ? 3'h0 : (k == 1) ? 3'h2 : 3'($urandom);
            nrst = 1'b0;
            jmp = code;
            step(20);
            expect_now(3'h0, 3'h0, 1'b0);
            nrst = 1'b1;
            step(3);
            jmp = ~code;
            step(2);
            expect_now(code, code, 1'b1);
            c2 = k[0] ? 3'h2 : 3'($urandom);
            we = 1'b1;
            sc = c2;
            step(1);
            we = 1'b0;
            step(1);
            expect_now(c2, code, 1'b1);
            // Load then restore back to back
            we = 1'b1;
            sc = ~code;
            step(1);
            we = 1'b0;
            rs = 1'b1;
            step(1);
            rs = 1'b0;
            step(1);
            expect_now(code, code, 1'b1);
            // Let the monitor compare before the next reset clears the port
            step(1);
        end
        wrap_up();
    end
endmodule
